/* File: verilog/ishi_params.svh */
// Purpose: Timing counts, offsets and reset values of the host port
// Assumes: 10 MHz core clock
// Notes:   Definitions only
`ifndef ISHI_PARAMS_SVH
`define ISHI_PARAMS_SVH
`define ISHI_CLK_NS         100
`define ISHI_BLANK_FAST_NS  20
`define ISHI_BLANK_SLOW_NS  200
`define ISHI_BLANK_FAST_CYC ((`ISHI_BLANK_FAST_NS + `ISHI_CLK_NS - 1) / `ISHI_CLK_NS)
`define ISHI_BLANK_SLOW_CYC ((`ISHI_BLANK_SLOW_NS + `ISHI_CLK_NS - 1) / `ISHI_CLK_NS)
`define ISHI_RST_HOLD_US    100
`define ISHI_RST_HOLD_CYC   ((`ISHI_RST_HOLD_US * 1000 + `ISHI_CLK_NS - 1) / `ISHI_CLK_NS)
`define ISHI_RST_CNT_W      10
`define ISHI_LAMP_SCAN_CYC  16
`define ISHI_ADDR_DRIVE     7'h00
`define ISHI_ADDR_CFG       7'h01
`define ISHI_ADDR_FAULT     7'h02
`define ISHI_ADDR_RST       8'h80
`define ISHI_CFG_RST        8'h00
`define ISHI_CFG_LAMP       0
`define ISHI_CFG_CHANNEL_FAULT_LATCH_SYNC  1
`define ISHI_CFG_ISO        2
`define ISHI_CRC_INIT       5'h1f
`define ISHI_CRC_POLY       5'h15
`define ISHI_CRC_BITS_SHORT 5'd11
`define ISHI_CRC_BITS_LONG  5'd19
`define ISHI_PINS_RST       13'h1d00
`endif

/* File: verilog/ishi_pkg.sv */
// Purpose: Types shared by the host port files
// Assumes: Constants come from ishi_params.svh
// Notes:   Frame mode order follows {bit1, bit0}
package ishi_pkg;
  // Serial frame modes
  typedef enum logic [1:0] {
    FM_BYTE,
    FM_BYTE_CRC,
    FM_ADDR,
    FM_ADDR_CRC
  } ishi_fmode_e;

  // Fast-blanked host pins
  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic       ale;
    logic       sync;
    logic [7:0] bus;
  } ishi_pins_s;

  // Slow-blanked strap pins
  typedef struct packed {
    logic port_type;
    logic fm1;
    logic fm0;
  } ishi_strap_s;

  // Open-drain or three-state pin drive
  typedef struct packed {
    logic o;
    logic oe_n;
  } ishi_od_s;
endpackage

/* File: verilog/ishi_blank.sv */
// Purpose: Two-flop synchroniser plus blanking filter for a pin group
// Assumes: Pins are asynchronous to clk
// Notes:   A change is taken once stable for STABLE cycles
`timescale 1ns/1ns
module ishi_blank #(
  parameter int           W       = 1,
  parameter int           STABLE  = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [7:0]   cnt;
    logic [W-1:0] q;
  } ishi_blk_s;

  ishi_blk_s st_r, st_nxt;

  // First stage feeds only the second; count stability of the second
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pin;
    st_nxt.s2 = st_r.s1;
    if (st_r.s2 == st_r.q) begin
      st_nxt.cnt = 8'h00;
    end else if (st_r.cnt >= 8'(STABLE - 1)) begin
      st_nxt.q   = st_r.s2;
      st_nxt.cnt = 8'h00;
    end else begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '{s1: RST_VAL, s2: RST_VAL, cnt: 8'h00, q: RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.q;
endmodule // ishi_blank

/* File: verilog/ishi_host_port.sv */
// Purpose: Host port of an isolated eight-channel switch: parallel and serial
// Assumes: Power-stage status inputs are on clk; sclk is the serial link clock
// Notes:   Bus pins are split into value and active-low enable; lamp pins are active-low enables only
`timescale 1ns/1ns
`include "ishi_params.svh"

module ishi_host_port (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              sclk,
  input  wire ishi_pkg::ishi_pins_s  pins,
  input  wire ishi_pkg::ishi_strap_s strap,
  input  wire logic              output_kill_n,
  input  wire logic              sdi,
  input  wire logic              supply_fault,
  input  wire logic              link_fault,
  input  wire logic [7:0]        ch_channel_fault_latch,
  output logic      [7:0]        out_ch,
  output logic      [7:0]        muxed_bus_o,
  output logic      [7:0]        muxed_bus_oe_n,
  output logic                   sdo,
  output logic                   sdo_oe_n,
  output ishi_pkg::ishi_od_s     fault_flag_n,
  output ishi_pkg::ishi_od_s     check_fault_n,
  output logic      [2:0]        lamp_row_oe_n,
  output logic      [2:0]        lamp_col_oe_n
);
  import ishi_pkg::*;

  // ********************************************************
  // Types and helpers
  // ********************************************************
  typedef struct packed {
    logic                       kill_s1;
    logic                       kill_s2;
    logic                       cs_q;
    logic                       wr_q;
    logic [7:0]                 addr;
    logic [7:0]                 drive;
    logic [7:0]                 applied;
    logic [7:0]                 cfg;
    logic [7:0]                 flt_latch;
    logic [`ISHI_RST_CNT_W-1:0] rst_cnt;
    logic [26:0]                snap1;
    logic [26:0]                snap2;
    logic [23:0]                txw;
    logic                       chk_err;
    logic                       flt_oe_n;
    logic [7:0]                 bus_o;
    logic [7:0]                 bus_oe_n;
    logic                       sdo_oe_n;
    logic [3:0]                 scan_cnt;
    logic [1:0]                 row;
    logic [2:0]                 row_oe_n;
    logic [2:0]                 col_oe_n;
  } ishi_core_s;

  typedef struct packed {
    logic [2:0]  cnt;
    logic [23:0] shift;
    logic [23:0] tx;
  } ishi_link_s;

  localparam ishi_core_s CORE_RST = '{
    kill_s1: 1'b0, kill_s2: 1'b0, cs_q: 1'b1, wr_q: 1'b1,
    addr: `ISHI_ADDR_RST, drive: 8'h00, applied: 8'h00,
    cfg: `ISHI_CFG_RST, flt_latch: 8'h00, rst_cnt: '0,
    snap1: 27'h0000000, snap2: 27'h0000000, txw: 24'h000000,
    chk_err: 1'b0, flt_oe_n: 1'b1, bus_o: 8'h00, bus_oe_n: 8'hff,
    sdo_oe_n: 1'b1, scan_cnt: 4'h0, row: 2'd0,
    row_oe_n: 3'h7, col_oe_n: 3'h7};

  // Checksum over the low n bits of d, most significant first
  function automatic logic [4:0] crc5(input logic [18:0] d, input logic [4:0] n);
    logic [4:0] c;
    logic       fb;
    c = `ISHI_CRC_INIT;
    for (int i = 18; i >= 0; i--) begin
      if (i < int'(n)) begin
        fb = c[4] ^ d[i];
        c  = {c[3:0], 1'b0};
        if (fb) begin
          c = c ^ `ISHI_CRC_POLY;
        end
      end
    end
    return c;
  endfunction

  // Register read mux, shared by both port types
  function automatic logic [7:0] rd_mux(input logic [6:0] a, input ishi_core_s s);
    if (a == `ISHI_ADDR_DRIVE) begin
      return s.drive;
    end else if (a == `ISHI_ADDR_CFG) begin
      return s.cfg;
    end else if (a == `ISHI_ADDR_FAULT) begin
      return s.flt_latch;
    end else begin
      return 8'h00;
    end
  endfunction

  // ********************************************************
  // Pin qualification
  // ********************************************************
  ishi_pins_s  fp;
  ishi_strap_s fs;

  // Both groups synchronise then blank
  ishi_blank #(.W(13), .STABLE(`ISHI_BLANK_FAST_CYC), .RST_VAL(`ISHI_PINS_RST)) u_fast (
    .clk (clk),
    .rst (rst),
    .pin (pins),
    .q   (fp)
  );

  // Straps reset to zero, so start-up is parallel
  ishi_blank #(.W(3), .STABLE(`ISHI_BLANK_SLOW_CYC), .RST_VAL(3'h0)) u_slow (
    .clk (clk),
    .rst (rst),
    .pin (strap),
    .q   (fs)
  );

  // ********************************************************
  // Serial link domain
  // ********************************************************
  ishi_core_s  st_r, st_nxt;
  ishi_link_s  lk_r, lk_nxt;
  logic        lk_start_r;
  logic        sdo_r;
  logic [23:0] txw_static;

  // txw only changes while deselected, so it is static during a frame
  assign txw_static = st_r.txw;

  always_comb begin
    lk_nxt       = lk_r;
    lk_nxt.cnt   = (lk_start_r ? 3'd0 : lk_r.cnt) + 3'd1;
    lk_nxt.shift = {lk_r.shift[22:0], sdi};
    lk_nxt.tx    = lk_start_r ? {txw_static[22:0], sdi} : {lk_r.tx[22:0], sdi};
  end

  always_ff @(posedge sclk) begin
    lk_r <= lk_nxt;
  end

  // Deselect marks the next rising edge as the first of a frame
  always_ff @(posedge sclk or posedge pins.cs_n) begin
    if (pins.cs_n) begin
      lk_start_r <= 1'b1;
    end else begin
      lk_start_r <= 1'b0;
    end
  end

  // Output shifts on the falling edge, half a period ahead of sampling
  always_ff @(negedge sclk or posedge pins.cs_n) begin
    if (pins.cs_n) begin
      sdo_r <= 1'b0;
    end else begin
      sdo_r <= lk_r.tx[23];
    end
  end

  // ********************************************************
  // Core state update
  // ********************************************************
  ishi_fmode_e fm;
  logic        serial;
  logic        cs_rise;
  logic        wr_rise;
  logic        we;
  logic [6:0]  wa;
  logic [7:0]  wd;
  logic [23:0] rx;
  logic [2:0]  flags;

  assign fm      = ishi_fmode_e'({fs.fm1, fs.fm0});
  assign serial  = fs.port_type;
  assign cs_rise = fp.cs_n & ~st_r.cs_q;
  assign wr_rise = fp.wr_n & ~st_r.wr_q;
  assign flags   = {supply_fault, link_fault, |ch_channel_fault_latch};

  always_comb begin
    st_nxt         = st_r;
    we             = 1'b0;
    wa             = 7'h00;
    wd             = 8'h00;
    rx             = st_r.snap2[23:0];
    st_nxt.kill_s1 = output_kill_n;
    st_nxt.kill_s2 = st_r.kill_s1;
    st_nxt.cs_q    = fp.cs_n;
    st_nxt.wr_q    = fp.wr_n;
    st_nxt.snap1   = {lk_r.cnt, lk_r.shift};
    st_nxt.snap2   = st_r.snap1;
    st_nxt.bus_oe_n = 8'hff;
    st_nxt.sdo_oe_n = ~(serial & ~fp.cs_n);
    if (!serial) begin
      // Address phase latches the bus; strobes are idle there
      if (!fp.cs_n && fp.ale) begin
        st_nxt.addr = fp.bus;
      end
      // Write captured at strobe rise to the held address
      if (!fp.cs_n && !fp.ale && wr_rise && st_r.addr[7]) begin
        we = 1'b1;
        wa = st_r.addr[6:0];
        wd = fp.bus;
      end
      // Tied-low write strobe, read strobe high, passes the bus through to the command at address 80
      if (!fp.cs_n && !fp.wr_n && !fp.ale && fp.rd_n && st_r.addr == `ISHI_ADDR_RST) begin
        we = 1'b1;
        wa = `ISHI_ADDR_DRIVE;
        wd = fp.bus;
      end
      // Read drives the bus only while selected and strobed
      if (!fp.cs_n && !fp.rd_n && !fp.ale && !st_r.addr[7]) begin
        st_nxt.bus_o    = rd_mux(st_r.addr[6:0], st_r);
        st_nxt.bus_oe_n = 8'h00;
      end
    end else if (cs_rise) begin
      // Frame ends at deselect; the link clock has stopped by now
      if (st_r.snap2[26:24] != 3'd0) begin
        st_nxt.chk_err = 1'b1;
      end else begin
        st_nxt.chk_err = 1'b0;
        case (fm)
          FM_BYTE: begin
            we = 1'b1;
            wa = `ISHI_ADDR_DRIVE;
            wd = rx[7:0];
          end
          FM_BYTE_CRC: begin
            if (crc5({8'h00, rx[15:5]}, `ISHI_CRC_BITS_SHORT) != rx[4:0]) begin
              st_nxt.chk_err = 1'b1;
            end else begin
              we = 1'b1;
              wa = `ISHI_ADDR_DRIVE;
              wd = rx[15:8];
            end
          end
          FM_ADDR: begin
            st_nxt.addr = rx[15:8];
            we = rx[15];
            wa = rx[14:8];
            wd = rx[7:0];
          end
          FM_ADDR_CRC: begin
            if (crc5(rx[23:5], `ISHI_CRC_BITS_LONG) != rx[4:0]) begin
              st_nxt.chk_err = 1'b1;
            end else begin
              st_nxt.addr = rx[23:16];
              we = rx[23];
              wa = rx[22:16];
              wd = rx[15:8];
            end
          end
          default: begin
            we = 1'b0;
          end
        endcase
      end
    end
    // Register writes
    if (we && wa == `ISHI_ADDR_DRIVE) begin
      st_nxt.drive = wd;
    end else if (we && wa == `ISHI_ADDR_CFG) begin
      st_nxt.cfg = wd;
    end
    // Kill wins over any drive write in the same cycle
    if (!st_r.kill_s2) begin
      st_nxt.drive = 8'h00;
    end
    // Output stage follows the command unless frozen by the strobe
    if (!st_r.cfg[`ISHI_CFG_ISO] || fp.sync) begin
      st_nxt.applied = st_r.drive;
    end
    if (!st_r.kill_s2) begin
      st_nxt.applied = 8'h00;
    end
    // Diagnostics latch every cycle or only while the strobe is high
    if (!st_r.cfg[`ISHI_CFG_CHANNEL_FAULT_LATCH_SYNC] || fp.sync) begin
      st_nxt.flt_latch = ch_channel_fault_latch;
    end
    st_nxt.flt_oe_n = ~(|flags);
    // Return word is rebuilt only between frames so the link sees it static
    if (fp.cs_n) begin
      case (fm)
        FM_BYTE:     st_nxt.txw = {st_r.flt_latch, 16'h0000};
        FM_BYTE_CRC: st_nxt.txw = {st_r.flt_latch, flags,
                                   crc5({8'h00, st_r.flt_latch, flags},
                                        `ISHI_CRC_BITS_SHORT), 8'h00};
        FM_ADDR:     st_nxt.txw = {st_r.flt_latch, rd_mux(st_r.addr[6:0], st_r), 8'h00};
        default:     st_nxt.txw = {st_r.flt_latch, rd_mux(st_r.addr[6:0], st_r), flags,
                                   crc5({st_r.flt_latch, rd_mux(st_r.addr[6:0], st_r),
                                         flags}, `ISHI_CRC_BITS_LONG)};
      endcase
    end
    // Lamp matrix scan, one row at a time
    st_nxt.scan_cnt = st_r.scan_cnt + 4'h1;
    if (st_r.scan_cnt == 4'(`ISHI_LAMP_SCAN_CYC - 1)) begin
      st_nxt.row = (st_r.row == 2'd2) ? 2'd0 : st_r.row + 2'd1;
    end
    st_nxt.row_oe_n = 3'h7;
    st_nxt.col_oe_n = 3'h7;
    if (serial && st_r.cfg[`ISHI_CFG_LAMP]) begin
      st_nxt.row_oe_n = ~(3'h1 << st_r.row);
      for (int c = 0; c < 3; c++) begin
        if (int'(st_r.row) * 3 + c < 8) begin
          st_nxt.col_oe_n[c] = ~st_r.applied[int'(st_r.row) * 3 + c];
        end
      end
    end
    // Long select plus address phase restarts the interface
    if (!fp.cs_n && fp.ale) begin
      st_nxt.rst_cnt = st_r.rst_cnt + `ISHI_RST_CNT_W'(1);
    end else begin
      st_nxt.rst_cnt = '0;
    end
    if (st_r.rst_cnt == `ISHI_RST_CNT_W'(`ISHI_RST_HOLD_CYC - 1)) begin
      st_nxt = CORE_RST;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= CORE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign out_ch         = st_r.applied;
  assign muxed_bus_o    = st_r.bus_o;
  assign muxed_bus_oe_n = st_r.bus_oe_n;
  assign sdo            = sdo_r;
  assign sdo_oe_n       = st_r.sdo_oe_n;
  assign fault_flag_n   = '{o: 1'b0, oe_n: st_r.flt_oe_n};
  assign check_fault_n  = '{o: 1'b0, oe_n: ~st_r.chk_err};
  assign lamp_row_oe_n  = st_r.row_oe_n;
  assign lamp_col_oe_n  = st_r.col_oe_n;

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_kill_off;
    !st_r.kill_s2 |=> (out_ch == 8'h00) [*2];
  endproperty
  a_kill_off: assert property (p_kill_off) else $error("outputs on while killed");

  property p_kill_clear;
    !st_r.kill_s2 ##1 st_r.kill_s2 |-> st_r.drive == 8'h00;
  endproperty
  a_kill_clear: assert property (p_kill_clear) else $error("command kept over kill");

  property p_serial_bus_idle;
    serial |=> muxed_bus_oe_n == 8'hff;
  endproperty
  a_serial_bus_idle: assert property (p_serial_bus_idle) else $error("bus driven in serial");

  property p_freeze;
    st_r.cfg[`ISHI_CFG_ISO] && !fp.sync && st_r.kill_s2 |=> $stable(out_ch);
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");

  property p_sync_rise;
    st_r.cfg[`ISHI_CFG_ISO] && $rose(fp.sync) && st_r.kill_s2 |=> out_ch == $past(st_r.drive);
  endproperty
  a_sync_rise: assert property (p_sync_rise) else $error("strobe rise missed transfer");

  property p_cs_release;
    fp.cs_n |=> muxed_bus_oe_n == 8'hff;
  endproperty
  a_cs_release: assert property (p_cs_release) else $error("bus driven while deselected");

  property p_soft_reset;
    st_r.rst_cnt == `ISHI_RST_CNT_W'(`ISHI_RST_HOLD_CYC - 1) |=> st_r.addr == `ISHI_ADDR_RST && st_r.drive == 8'h00;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("hold reset not taken");

  property p_sdo_release;
    fp.cs_n |=> sdo_oe_n;
  endproperty
  a_sdo_release: assert property (p_sdo_release) else $error("serial output driven");

  property p_fault_flag;
    (supply_fault || link_fault || |ch_channel_fault_latch) |=> !fault_flag_n.oe_n;
  endproperty
  a_fault_flag: assert property (p_fault_flag) else $error("fault not flagged");

  property p_count_err;
    serial && cs_rise && st_r.snap2[26:24] != 3'd0 |=> !check_fault_n.oe_n;
  endproperty
  a_count_err: assert property (p_count_err) else $error("count error not flagged");

  property p_lamp_off;
    !(serial && st_r.cfg[`ISHI_CFG_LAMP]) |=> lamp_row_oe_n == 3'h7 && lamp_col_oe_n == 3'h7;
  endproperty
  a_lamp_off: assert property (p_lamp_off) else $error("lamp pins driven");

  c_par_write: cover property (!serial && wr_rise && !fp.cs_n && st_r.addr[7]);
  c_par_read: cover property (!serial && !muxed_bus_oe_n[0]);
  c_ser_frame: cover property (serial && cs_rise && !st_r.chk_err);
endmodule // ishi_host_port

/* File: tb/ishi_spi_master.sv */
// Purpose: Serial master standing on the far side of the host port
// Assumes: Shift clock idles low between frames, period 32 ns
// Notes:   Data lines fall to the pull-down level once released
`timescale 1ns/1ns
module ishi_spi_master (
  output logic sclk,
  output logic sdi
);
  // ****************
  // Frame generation
  // ****************
  initial begin
    sclk = 1'b0;
    sdi  = 1'b0;
  end

  // Shifts n bits MSB first; sdi moves only while sclk is low
  task automatic frame(input logic [23:0] d, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      sdi = d[i];
      #16 sclk = 1'b1; // Device samples on this rise
      #16 sclk = 1'b0;
    end
    sdi = 1'b0; // Released: pulled down, not left at last value
  endtask
endmodule // ishi_spi_master

/* File: tb/ishi_host_port_bench.sv */
// Purpose: Self-checking bench for the host port, parallel and serial
// Assumes: Filtered pins settle within 8 core cycles
// Notes:   Lamp scan order is not checked, only that a row is pulled
`timescale 1ns/1ns
module ishi_host_port_bench;
  import ishi_pkg::*;
  logic              clk, rst, cs_n, rd_n, wr_n, ale, sync, kill_n, sup_f;
  logic [7:0]        host_bus, bus_res, out_ch, bus_o, bus_oe_n;
  ishi_strap_s       strap;
  ishi_pins_s        pins;
  ishi_od_s          flt, chk;
  logic              sclk, sdi, sdo, sdo_oe_n;
  logic [2:0]        row_oe_n;
  int                mismatches, checks, cyc;

  // Bus wire: the device wins on lanes it enables
  assign bus_res = (~bus_oe_n & bus_o) | (bus_oe_n & host_bus);
  assign pins    = {cs_n, rd_n, wr_n, ale, sync, bus_res};

  ishi_host_port u_dut (.clk(clk), .rst(rst), .sclk(sclk), .pins(pins), .strap(strap),
    .output_kill_n(kill_n), .sdi(sdi), .supply_fault(sup_f), .link_fault(1'b0),
    .ch_channel_fault_latch(8'h00), .out_ch(out_ch), .muxed_bus_o(bus_o), .muxed_bus_oe_n(bus_oe_n),
    .sdo(sdo), .sdo_oe_n(sdo_oe_n), .fault_flag_n(flt), .check_fault_n(chk),
    .lamp_row_oe_n(row_oe_n), .lamp_col_oe_n());
  ishi_spi_master u_m (.sclk(sclk), .sdi(sdi));

  // ***************
  // Helper tasks
  // ***************
  always #50 clk = ~clk;

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Cut a hang short well past the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Inputs other than sclk and sdi move 10 ns after a rising edge
  task automatic pw(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask

  task automatic latch(input logic [7:0] a);
    cs_n = 1'b0;
    ale = 1'b1; // Strobes stay high meanwhile
    host_bus = a;
    pw(6);
    ale = 1'b0;
    pw(2);
  endtask

  task automatic pwrite(input logic [7:0] a, input logic [7:0] d);
    latch(a);
    host_bus = d;
    wr_n = 1'b0;
    pw(4);
    wr_n = 1'b1;
    pw(6);
    cs_n = 1'b1;
    pw(2);
  endtask

  task automatic pread(input logic [7:0] exp);
    rd_n = 1'b0;
    pw(7);
    cmp8("read data", exp, bus_o);
    cmp8("read drive", 8'h00, bus_oe_n);
    rd_n = 1'b1;
    pw(6);
  endtask

  task automatic sframe(input logic [23:0] d, input int n);
    cs_n = 1'b0;
    pw(6);
    cmp8("sdo enable", 8'h00, {7'h0, sdo_oe_n});
    u_m.frame(d, n);
    pw(1);
    cs_n = 1'b1;
    pw(8);
  endtask

  // ***************
  // Main sequence
  // ***************
  initial begin
    clk = 1'b0; rst = 1'b1; cs_n = 1'b1; rd_n = 1'b1; wr_n = 1'b1; ale = 1'b0;
    sync = 1'b1; kill_n = 1'b1; sup_f = 1'b0; host_bus = 8'h00; strap = '0;
    mismatches = 0; checks = 0; cyc = 0;
    pw(8);
    rst = 1'b0;
    pw(6);
    cmp8("out after reset", 8'h00, out_ch);
    cmp8("bus released", 8'hff, bus_oe_n);
    cmp8("fault idle", 8'h01, {7'h0, flt.oe_n});
    pwrite(8'h80, 8'ha5);
    cmp8("out after write", 8'ha5, out_ch);
    latch(8'h00);
    pread(8'ha5);
    pread(8'ha5); // Same address again, no increment
    cs_n = 1'b1;
    pw(6);
    cmp8("bus released", 8'hff, bus_oe_n);
    kill_n = 1'b0;
    pw(50); // Held the minimum 5 us
    cmp8("out under kill", 8'h00, out_ch);
    kill_n = 1'b1;
    pw(8);
    cmp8("out after kill", 8'h00, out_ch);
    sup_f = 1'b1;
    pw(3);
    cmp8("fault flag", 8'h00, {7'h0, flt.oe_n});
    sup_f = 1'b0;
    pw(3);
    cmp8("fault cleared", 8'h01, {7'h0, flt.oe_n});
    pwrite(8'h81, 8'h04); // Isochronous on
    sync = 1'b0;
    pw(6);
    pwrite(8'h80, 8'h5a);
    cmp8("out frozen", 8'h00, out_ch);
    sync = 1'b1;
    pw(6);
    cmp8("out on strobe", 8'h5a, out_ch);
    // Select plus address phase held past the hold-reset time
    cs_n = 1'b0;
    ale = 1'b1;
    pw(1005);
    ale = 1'b0;
    cs_n = 1'b1;
    pw(8);
    cmp8("out after hold", 8'h00, out_ch);
    strap = '{port_type: 1'b1, fm1: 1'b0, fm0: 1'b0};
    pw(8);
    cmp8("sdo idle", 8'h01, {7'h0, sdo_oe_n});
    sframe(24'h00003c, 8);
    cmp8("serial drive", 8'h3c, out_ch);
    cmp8("check ok", 8'h01, {7'h0, chk.oe_n});
    sframe(24'h000055, 7);
    cmp8("count error", 8'h00, {7'h0, chk.oe_n});
    cmp8("frame dropped", 8'h3c, out_ch);
    strap = '{port_type: 1'b1, fm1: 1'b1, fm0: 1'b0};
    pw(8);
    sframe(24'h008101, 16); // Config write, lamp on
    pw(4);
    cmp8("check cleared", 8'h01, {7'h0, chk.oe_n});
    cmp8("lamp row", 8'h00, {7'h0, &row_oe_n});
    conclude();
  end
endmodule // ishi_host_port_bench
